/* File: src/ast_pkg.sv */
/*
 * Shared constants and types for the asynchronous serial transceiver:
 * oversampling figures, frame sizes, receiver states, the FIFO entry and
 * the transceiver's state record, which leaves out the receive FIFO.
 * Assumes one system clock; every slower rate is an enable pulse.
 */
`default_nettype none
package ast_pkg;

    // Oversampling and baud timer
    localparam int AST_OVERSAMPLE = 16;
    localparam int AST_DIV_W = 8;
    localparam logic [3:0] AST_TICK_LAST = 4'(AST_OVERSAMPLE - 1);
    localparam logic [3:0] AST_VOTE_A = 4'h6;
    localparam logic [3:0] AST_VOTE_B = 4'h7;
    localparam logic [3:0] AST_CENTRE = 4'h8;

    // Frame sizes
    localparam logic [3:0] AST_FRAME_BASE = 4'ha;
    localparam logic [3:0] AST_DATA_BITS_8 = 4'h8;
    localparam int AST_RX_FIFO_DEPTH = 2;
    localparam logic [8:0] AST_IDLE_LINE = 9'h1ff;

    // Receiver states, Gray along idle-start-data-stop
    typedef enum logic [1:0] {
        AST_RX_IDLE = 2'h0,
        AST_RX_START = 2'h1,
        AST_RX_DATA = 2'h3,
        AST_RX_STOP = 2'h2
    } ast_rx_state_e;

    // One received character as stored in the FIFO
    typedef struct packed {
        logic framing_error_flag;
        logic ninth;
        logic [7:0] data;
    } ast_rx_char_s;

    // State of the transceiver, apart from the receive FIFO
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        logic [AST_DIV_W-1:0] baud_cnt;
        logic tick;
        logic [3:0] tx_ticks;
        logic tx_buf_full;
        logic [8:0] tx_buf;
        logic [11:0] tx_shift;
        logic [3:0] tx_bits;
        logic tx_empty;
        logic tx_pin;
        logic tx_oe_n;
        logic tx_flag;
        ast_rx_state_e rx_state;
        logic [3:0] rx_ticks;
        logic [1:0] rx_vote;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift;
        logic overrun_error_flag;
        logic framing_error_flag;
        logic rx9;
        logic [7:0] rx_data;
        logic rx_flag;
        logic rx_idle;
        logic rx_oe_n;
        logic irq;
    } ast_state_s;

    // Values after reset: line idle high, shifter empty, pins undriven
    localparam ast_state_s AST_STATE_RST = '{
        rx_s1: 1'b1, rx_s2: 1'b1, rx_prev: 1'b1, baud_cnt: 8'h00, tick: 1'b0,
        tx_ticks: 4'h0, tx_buf_full: 1'b0, tx_buf: 9'h000, tx_shift: 12'hfff,
        tx_bits: 4'h0, tx_empty: 1'b1, tx_pin: 1'b1, tx_oe_n: 1'b1, tx_flag: 1'b0,
        rx_state: AST_RX_IDLE, rx_ticks: 4'h0, rx_vote: 2'h0, rx_bits: 4'h0,
        rx_shift: 9'h000, overrun_error_flag: 1'b0, framing_error_flag: 1'b0, rx9: 1'b0, rx_data: 8'h00,
        rx_flag: 1'b0, rx_idle: 1'b1, rx_oe_n: 1'b1, irq: 1'b0
    };

endpackage
`default_nettype wire

/* File: src/ast_transceiver.sv */
/*
 * Asynchronous serial transceiver: baud timer, transmit buffer and
 * shifter, 16x oversampled receiver, receive FIFO and status flags.
 * Assumes control inputs come from software logic on clk_i; the receive
 * pin is asynchronous and is synchronised here.
 */
// Overview of operation
// - Shifter-empty status is 1 when idle, cleared on load until all bits sent.
// - Shifter-empty status is read-only and never interrupts; software polls it.
// - Nine-bit transmit sends the ninth-bit value as the most significant data bit.
// - Software writes ninth bit first; the buffer write hands nine bits over together.
// - Enabling the transmitter sets the buffer-empty flag.
// - Transmit interrupt fires at once when all three enables and the flag are set.
// - Receive recovery runs at sixteen times baud; the shifter advances per bit.
// - Completed characters enter a two-entry FIFO; plus a third start bit in flight.
// - Enabled transmitter drives its pin; enabled receiver keeps its pin as input.
// - Falling edge, wait half a bit; if line not low, drop silently and rearm.
// - After a valid start, sample each bit centre by majority vote into the shifter.
// - Stop position sampled low sets that character's framing error, high clears it.
// - Finished characters enter the FIFO; each data read removes the oldest.
// - Receive flag is set while enabled with unread data; software cannot write it.
// - Receive interrupt needs receive, peripheral and global enables all set.
// - Framing error is stored per entry and shown after the data read.
// - Framing errors do not stop reception or interrupt; port disable clears all.
// - Third completed character with a full FIFO sets overrun and is dropped.
// - Overrun clears when continuous receive or the port enable is cleared.
// - Nine-bit receive shifts nine bits; ninth bit is read after the data.
// - Eight-bit divisor sets a free-running timer; rate is clock over 16(n+1).
// - Stop select 1 gives one stop bit, 0 gives two.
// - Frame is low start, data LSB first, high stop bits; line idles high.
// - Buffered character loads one cycle after the previous stop bit ends.
`timescale 1ns/1ps
`default_nettype none

module ast_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clr_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } ast_fifo_state_s;

    ast_fifo_state_s r, n;
    logic push, pop;

    // Full and empty come straight from the occupancy count
    assign in_ready_o = (r.cnt != FULL);
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o = r.mem[r.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    // Pointer wrap written out so depths need not be powers of two
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data_i;
            n.wr = (r.wr == LAST) ? '0 : AW'(r.wr + 1'b1);
        end
        if (pop) begin
            n.rd = (r.rd == LAST) ? '0 : AW'(r.rd + 1'b1);
        end
        n.cnt = CW'(r.cnt + CW'(push) - CW'(pop));
        if (clr_i) begin
            n.wr = '0;
            n.rd = '0;
            n.cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // ast_fifo

module ast_transceiver (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic serial_port_enable_i,
    input wire logic sync_mode_i,
    input wire logic tx_enable_bit_i,
    input wire logic continuous_rx_enable_i,
    input wire logic tx_ninth_bit_enable_i,
    input wire logic tx_ninth_bit_value_i,
    input wire logic rx_ninth_bit_enable_i,
    input wire logic stop_length_select_i,
    input wire logic [ast_pkg::AST_DIV_W-1:0] baud_divisor_i,
    input wire logic baud_divisor_wr_i,
    input wire logic tx_buffer_wr_i,
    input wire logic [7:0] tx_buffer_data_i,
    input wire logic rx_data_rd_i,
    input wire logic tx_irq_enable_i,
    input wire logic rx_irq_enable_i,
    input wire logic peripheral_irq_enable_i,
    input wire logic global_irq_enable_i,
    input wire logic tx_pin_direction_i,
    input wire logic rx_pin_direction_i,
    input wire logic rx_pin_i,
    output logic tx_pin_o,
    output logic tx_pin_oe_n_o,
    output logic rx_pin_oe_n_o,
    output logic tx_shifter_empty_o,
    output logic tx_buffer_empty_flag_o,
    output logic rx_data_flag_o,
    output logic [7:0] rx_data_o,
    output logic rx_ninth_bit_value_o,
    output logic framing_error_flag_o,
    output logic overrun_error_flag_o,
    output logic rx_idle_o,
    output logic irq_o
);
    import ast_pkg::*;

    ast_state_s r, n;
    ast_rx_char_s push_d, head_d;
    logic push_v, fifo_ready, fifo_valid, pop;
    logic port_on, tx_on, rx_on, maj, edge_seen, tx_load;
    logic [11:0] frame;

    // Asynchronous mode only: synchronous select keeps the port idle
    assign port_on = serial_port_enable_i && !sync_mode_i;
    assign tx_on = port_on && tx_enable_bit_i;
    assign rx_on = port_on && continuous_rx_enable_i;
    assign pop = rx_data_rd_i && r.rx_flag;

    // Two entries plus the shifter hold two characters and a third start
    ast_fifo #(
        .W($bits(ast_rx_char_s)),
        .DEPTH(AST_RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(!port_on),
        .in_valid_i(push_v),
        .in_ready_o(fifo_ready),
        .in_data_i(push_d),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(head_d)
    );

    // Next state of the transceiver, all but the receive FIFO
    always_comb begin
        n = r;
        push_v = 1'b0;
        push_d = '0;
        maj = 1'b0;
        frame = '1;
        tx_load = 1'b0;
        // Receive pin synchroniser; first stage feeds only the second
        n.rx_s1 = rx_pin_i;
        n.rx_s2 = r.rx_s1;
        n.rx_prev = r.rx_s2;
        edge_seen = r.rx_prev && !r.rx_s2;

        // Free-running baud timer, restarted by a divisor write
        n.tick = 1'b0;
        if (baud_divisor_wr_i) begin
            n.baud_cnt = baud_divisor_i;
        end else if (r.baud_cnt == '0) begin
            n.baud_cnt = baud_divisor_i;
            n.tick = 1'b1;
        end else begin
            n.baud_cnt = r.baud_cnt - 1'b1;
        end

        // Transmit shifter: each bit lasts sixteen ticks
        if (!r.tx_empty && r.tick) begin
            n.tx_ticks = r.tx_ticks + 1'b1;
            if (r.tx_ticks == AST_TICK_LAST) begin
                n.tx_shift = {1'b1, r.tx_shift[11:1]};
                n.tx_bits = r.tx_bits - 1'b1;
                if (r.tx_bits == 4'h1) begin
                    n.tx_empty = 1'b1;
                end
            end
        end
        // Load waits one cycle past the stop bit since empty is registered
        if (r.tx_empty && r.tx_buf_full && tx_on) begin
            tx_load = 1'b1;
            frame = tx_ninth_bit_enable_i ? {2'b11, r.tx_buf, 1'b0}
                                          : {3'b111, r.tx_buf[7:0], 1'b0};
            n.tx_shift = frame;
            n.tx_bits = AST_FRAME_BASE + 4'(tx_ninth_bit_enable_i)
                        + 4'(!stop_length_select_i);
            n.tx_ticks = '0;
            n.tx_empty = 1'b0;
            n.tx_buf_full = 1'b0;
        end
        // Ninth bit sampled with the data so all nine move together
        if (tx_buffer_wr_i && tx_on) begin
            n.tx_buf = {tx_ninth_bit_value_i, tx_buffer_data_i};
            n.tx_buf_full = 1'b1;
        end

        // Receiver: 16x recovery, vote at ticks 6, 7 and 8 of each bit
        maj = (r.rx_vote[1] & r.rx_vote[0]) | (r.rx_vote[1] & r.rx_s2)
              | (r.rx_vote[0] & r.rx_s2);
        case (r.rx_state)
            AST_RX_IDLE: begin
                if (edge_seen) begin
                    n.rx_state = AST_RX_START;
                    n.rx_ticks = '0;
                end
            end
            AST_RX_START, AST_RX_DATA, AST_RX_STOP: begin
                if (r.tick) begin
                    n.rx_ticks = r.rx_ticks + 1'b1;
                    if (r.rx_ticks == AST_VOTE_A || r.rx_ticks == AST_VOTE_B) begin
                        n.rx_vote = {r.rx_vote[0], r.rx_s2};
                    end
                    if (r.rx_ticks == AST_CENTRE) begin
                        if (r.rx_state == AST_RX_START) begin
                            n.rx_state = maj ? AST_RX_IDLE : AST_RX_DATA;
                            n.rx_bits = '0;
                        end else if (r.rx_state == AST_RX_DATA) begin
                            n.rx_shift = {maj, r.rx_shift[8:1]};
                            n.rx_bits = r.rx_bits + 1'b1;
                            if (r.rx_bits == AST_DATA_BITS_8 - 4'(!rx_ninth_bit_enable_i)) begin
                                n.rx_state = AST_RX_STOP;
                            end
                        end else begin
                            push_d.framing_error_flag = !maj;
                            push_d.ninth = rx_ninth_bit_enable_i && r.rx_shift[8];
                            push_d.data = rx_ninth_bit_enable_i ? r.rx_shift[7:0]
                                                                : r.rx_shift[8:1];
                            // Framing errors still store; overrun drops
                            push_v = !r.overrun_error_flag && fifo_ready;
                            if (!fifo_ready) begin
                                n.overrun_error_flag = 1'b1;
                            end
                            n.rx_state = AST_RX_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.rx_state = AST_RX_IDLE;
            end
        endcase
        if (!rx_on) begin
            n.rx_state = AST_RX_IDLE;
        end
        if (!continuous_rx_enable_i) begin
            n.overrun_error_flag = 1'b0;
        end

        // Status seen by the last data read stays until the next read
        if (pop) begin
            n.framing_error_flag = head_d.framing_error_flag;
            n.rx9 = head_d.ninth;
        end
        n.rx_data = head_d.data;
        n.rx_flag = rx_on && fifo_valid && !pop;
        n.rx_idle = (n.rx_state == AST_RX_IDLE);
        n.tx_flag = tx_on && !n.tx_buf_full;
        n.tx_pin = n.tx_empty ? 1'b1 : n.tx_shift[0];

        // Enabled ends override the direction settings
        n.tx_oe_n = tx_on ? 1'b0 : tx_pin_direction_i;
        n.rx_oe_n = rx_on ? 1'b1 : rx_pin_direction_i;

        // Port disable is a module reset; synchroniser keeps tracking
        if (!serial_port_enable_i) begin
            n = AST_STATE_RST;
            n.rx_s1 = rx_pin_i;
            n.rx_s2 = r.rx_s1;
            n.rx_prev = r.rx_s2;
            n.tx_oe_n = tx_pin_direction_i;
            n.rx_oe_n = rx_pin_direction_i;
        end
        // Interrupt gated by all three enables; errors never raise it
        n.irq = global_irq_enable_i && peripheral_irq_enable_i
                && ((tx_irq_enable_i && n.tx_flag) || (rx_irq_enable_i && n.rx_flag));
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= AST_STATE_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state record
    assign tx_pin_o = r.tx_pin;
    assign tx_pin_oe_n_o = r.tx_oe_n;
    assign rx_pin_oe_n_o = r.rx_oe_n;
    assign tx_shifter_empty_o = r.tx_empty;
    assign tx_buffer_empty_flag_o = r.tx_flag;
    assign rx_data_flag_o = r.rx_flag;
    assign rx_data_o = r.rx_data;
    assign rx_ninth_bit_value_o = r.rx9;
    assign framing_error_flag_o = r.framing_error_flag;
    assign overrun_error_flag_o = r.overrun_error_flag;
    assign rx_idle_o = r.rx_idle;
    assign irq_o = r.irq;

    // Checks on the transceiver's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    tx_load_clear_a: assert property (tx_load |=> !tx_shifter_empty_o && !tx_pin_o)
        else $error("shifter empty not cleared on load");
    tx_empty_hold_a: assert property ($rose(tx_shifter_empty_o) |-> $past(r.tx_bits) == 4'h1
        || !$past(serial_port_enable_i))
        else $error("shifter empty set before last bit");
    tx_flag_set_a: assert property (tx_on && !r.tx_buf_full && !tx_buffer_wr_i
        |=> tx_buffer_empty_flag_o)
        else $error("buffer empty flag missing while enabled");
    irq_gate_a: assert property (irq_o |-> $past(global_irq_enable_i)
        && $past(peripheral_irq_enable_i))
        else $error("interrupt without global enables");
    rx_irq_a: assert property ($past(global_irq_enable_i && peripheral_irq_enable_i
        && rx_irq_enable_i) && rx_data_flag_o |-> irq_o)
        else $error("receive interrupt not raised");
    framing_error_flag_hold_a: assert property (!pop && serial_port_enable_i
        |=> $stable(framing_error_flag_o))
        else $error("framing status changed without a read");
    rx_flag_on_a: assert property (rx_data_flag_o |-> $past(rx_on) && $past(fifo_valid))
        else $error("receive flag without data");
    false_start_a: assert property (r.rx_state == AST_RX_START && r.tick
        && r.rx_ticks == AST_CENTRE && maj && rx_on |=> r.rx_state == AST_RX_IDLE
        && !push_v)
        else $error("false start not dropped");
    overrun_set_a: assert property (r.rx_state == AST_RX_STOP && r.tick
        && r.rx_ticks == AST_CENTRE && !fifo_ready && rx_on && continuous_rx_enable_i
        |=> overrun_error_flag_o)
        else $error("overrun not flagged");
    overrun_clr_a: assert property (!continuous_rx_enable_i |=> !overrun_error_flag_o)
        else $error("overrun not cleared");
    port_off_a: assert property (!serial_port_enable_i |=> !framing_error_flag_o
        && tx_shifter_empty_o && !rx_data_flag_o ##1 !rx_data_flag_o)
        else $error("port disable did not reset");
    tx_pin_drive_a: assert property (tx_on |=> !tx_pin_oe_n_o)
        else $error("enabled transmitter not driving");
    // Reload value is the divisor seen one cycle before the tick
    baud_tick_a: assert property ((r.tick && !baud_divisor_wr_i
        && $past(baud_divisor_i) == 8'h01)
        ##1 (!baud_divisor_wr_i && serial_port_enable_i) |=> r.tick)
        else $error("baud period wrong");

    tx_frame_c: cover property (tx_load ##[1:1000] $rose(tx_shifter_empty_o));
    rx_char_c: cover property (push_v && !push_d.framing_error_flag);
    rx_framing_error_flag_c: cover property (push_v && push_d.framing_error_flag);
    overrun_c: cover property ($rose(overrun_error_flag_o));
    false_start_c: cover property (r.rx_state == AST_RX_START && r.tick
        && r.rx_ticks == AST_CENTRE && maj);
endmodule // ast_transceiver
`default_nettype wire

/* File: tb/ast_remote_node.sv */
/*
 * Behavioural remote serial node: drives frames onto the receive line
 * and captures frames from the transmit line.
 * Assumes the bench clock and a fixed bit length in clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ast_remote_node #(
    parameter int BIT_CLKS = 32
) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    // Line idles high between frames
    initial begin
        line_o = 1'b1;
    end
    // One level held for n cycles, changed just after an edge
    task automatic hold(input logic v, input int n);
        @(posedge clk_i);
        line_o <= v;
        repeat (n - 1) @(posedge clk_i);
    endtask
    // Low start, data LSB first, chosen stop level, then idle high
    task automatic send(input logic [8:0] d, input int nbits, input logic stop);
        hold(1'b0, BIT_CLKS);
        for (int i = 0; i < nbits; i++) begin
            hold(d[i], BIT_CLKS);
        end
        hold(stop, BIT_CLKS);
        hold(1'b1, BIT_CLKS);
    endtask
    // Short low pulse, too brief to pass the start check
    task automatic glitch(input int n);
        hold(1'b0, n);
        hold(1'b1, BIT_CLKS);
    endtask
    // Sample each bit centre; bounded wait for the start edge
    task automatic capture(output logic [8:0] d, input int nbits, output logic stop);
        int w;
        d = 9'h000;
        for (w = 0; w < 20000 && line_i !== 1'b0; w++) @(posedge clk_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            d[i] = line_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        stop = line_i;
    endtask
endmodule // ast_remote_node
`default_nettype wire

/* File: tb/ast_transceiver_tb.sv */
/*
 * Self-checking bench for the serial transceiver, with a remote node
 * on the line side.
 * Assumes divisor 1, so one bit lasts 32 clock cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module ast_transceiver_tb;
    import ast_pkg::*;
    localparam int BIT_CLKS = 32;
    logic clk_i, arst_n_i, port_en, tx_en, rx_en, tx9_on, tx9, rx9_on, stop_one, sync;
    logic div_wr, tx_wr, rx_rd, tx_ie, rx_ie, per_ie, glb_ie, tx_dir, rx_dir, rx_line;
    logic [7:0] div, tx_data, rx_data;
    logic tx_pin, tx_oe_n, rx_oe_n, tx_empty, tx_flag, rx_flag, rx9, framing_error_flag, overrun_error_flag, rx_idle, irq;
    logic [8:0] cap;
    logic stp;
    int bad_count = 0;
    int compares = 0;

    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ast_transceiver i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .serial_port_enable_i(port_en), .sync_mode_i(sync), .tx_enable_bit_i(tx_en),
        .continuous_rx_enable_i(rx_en), .tx_ninth_bit_enable_i(tx9_on),
        .tx_ninth_bit_value_i(tx9), .rx_ninth_bit_enable_i(rx9_on),
        .stop_length_select_i(stop_one), .baud_divisor_i(div), .baud_divisor_wr_i(div_wr),
        .tx_buffer_wr_i(tx_wr), .tx_buffer_data_i(tx_data), .rx_data_rd_i(rx_rd),
        .tx_irq_enable_i(tx_ie), .rx_irq_enable_i(rx_ie), .peripheral_irq_enable_i(per_ie),
        .global_irq_enable_i(glb_ie), .tx_pin_direction_i(tx_dir),
        .rx_pin_direction_i(rx_dir), .rx_pin_i(rx_line), .tx_pin_o(tx_pin),
        .tx_pin_oe_n_o(tx_oe_n), .rx_pin_oe_n_o(rx_oe_n), .tx_shifter_empty_o(tx_empty),
        .tx_buffer_empty_flag_o(tx_flag), .rx_data_flag_o(rx_flag), .rx_data_o(rx_data),
        .rx_ninth_bit_value_o(rx9), .framing_error_flag_o(framing_error_flag),
        .overrun_error_flag_o(overrun_error_flag), .rx_idle_o(rx_idle), .irq_o(irq));

    ast_remote_node #(.BIT_CLKS(BIT_CLKS)) i_node (.clk_i(clk_i), .line_i(tx_pin),
        .line_o(rx_line));

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Sample just after an edge, once its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Ninth bit travels with the buffer write pulse
    task automatic wr_tx(input logic [7:0] d, input logic n);
        @(posedge clk_i);
        tx_data <= d;
        tx9 <= n;
        tx_wr <= 1'b1;
        @(posedge clk_i);
        tx_wr <= 1'b0;
    endtask
    // Data checked before the read, status after it, as software must
    task automatic rd_rx(input logic [7:0] d, input logic f, input logic n);
        int w;
        for (w = 0; w < 2000 && rx_flag !== 1'b1; w++) tick(1);
        check("rx_flag", rx_flag, 1'b1);
        check("rx_data", rx_data, d);
        @(posedge clk_i);
        rx_rd <= 1'b1;
        @(posedge clk_i);
        rx_rd <= 1'b0;
        #1;
        check("framing_error", framing_error_flag, f);
        check("rx_ninth", rx9, n);
        tick(1);
    endtask
    // Busy span of the shifter compared with the frame length
    task automatic frame_len(input int bits);
        int w;
        for (w = 0; w < 2000 && tx_empty !== 1'b0; w++) tick(1);
        for (w = 0; w < 2000 && tx_empty !== 1'b1; w++) tick(1);
        check("frame_len", w >= bits * BIT_CLKS - 6 && w <= bits * BIT_CLKS + 2, 1'b1);
    endtask

    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (60000) @(posedge clk_i);
        $display("watchdog expired");
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {port_en, tx_en, rx_en, tx9_on, tx9, rx9_on, stop_one, sync} = 8'h00;
        {div_wr, tx_wr, rx_rd, tx_ie, rx_ie, per_ie, glb_ie} = 7'h00;
        {tx_dir, rx_dir, arst_n_i, div, tx_data} = {3'h6, 8'h01, 8'h00};
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        tick(1);
        check("tx_empty", tx_empty, 1'b1);
        check("tx_pin", tx_pin, 1'b1);
        check("rx_idle", rx_idle, 1'b1);
        @(posedge clk_i);
        {rx_dir, div_wr, port_en} <= 3'h3;
        @(posedge clk_i);
        div_wr <= 1'b0;
        #1;
        check("rx_oe_n", rx_oe_n, 1'b0);
        $display("test reset done");
        @(posedge clk_i);
        {tx_en, rx_en, tx_ie, per_ie, glb_ie} <= 5'h1f;
        tick(3);
        check("tx_flag", tx_flag, 1'b1);
        check("tx_oe_n", tx_oe_n, 1'b0);
        check("rx_oe_n", rx_oe_n, 1'b1);
        check("irq", irq, 1'b1);
        @(posedge clk_i);
        tx_ie <= 1'b0;
        tick(3);
        check("irq", irq, 1'b0);
        $display("test enables done");
        // Back-to-back pair with two stop bits
        fork
            begin
                i_node.capture(cap, 8, stp);
                check("tx_char", cap, 9'h0a5);
                check("tx_stop", stp, 1'b1);
                i_node.capture(cap, 8, stp);
                check("tx_char", cap, 9'h03c);
            end
            begin
                wr_tx(8'ha5, 1'b0);
                tick(3);
                check("tx_empty", tx_empty, 1'b0);
                wr_tx(8'h3c, 1'b0);
                tick(1);
                check("tx_flag", tx_flag, 1'b0);
                for (int w = 0; w < 2000 && tx_empty !== 1'b1; w++) tick(1);
                tick(1);
                check("tx_reload", tx_empty, 1'b0);
                frame_len(11);
            end
        join
        // Nine bits, one stop bit, ninth set to mark an address
        @(posedge clk_i);
        {tx9_on, stop_one} <= 2'h3;
        fork
            begin
                i_node.capture(cap, 9, stp);
                check("tx_char9", cap, 9'h15a);
            end
            begin
                wr_tx(8'h5a, 1'b1);
                frame_len(11);
            end
        join
        $display("test transmit done");
        @(posedge clk_i);
        {tx9_on, rx_ie} <= 2'h1;
        i_node.send(9'h03c, 8, 1'b1);
        tick(3);
        check("irq", irq, 1'b1);
        rd_rx(8'h3c, 1'b0, 1'b0);
        // Bad stop: flagged, no interrupt, reception goes on
        fork
            i_node.send(9'h0c3, 8, 1'b0);
            begin
                tick(2 * BIT_CLKS);
                check("rx_idle", rx_idle, 1'b0);
            end
        join
        rd_rx(8'hc3, 1'b1, 1'b0);
        tick(2);
        check("irq", irq, 1'b0);
        i_node.send(9'h055, 8, 1'b1);
        rd_rx(8'h55, 1'b0, 1'b0);
        i_node.glitch(6);
        tick(3 * BIT_CLKS);
        check("rx_flag", rx_flag, 1'b0);
        check("rx_idle", rx_idle, 1'b1);
        i_node.send(9'h081, 8, 1'b1);
        rd_rx(8'h81, 1'b0, 1'b0);
        $display("test receive done");
        // Three characters unread: third is lost and overrun set
        for (int i = 1; i < 4; i++) i_node.send(9'h0a0 + 9'(i), 8, 1'b1);
        tick(4);
        check("overrun", overrun_error_flag, 1'b1);
        rd_rx(8'ha1, 1'b0, 1'b0);
        rd_rx(8'ha2, 1'b0, 1'b0);
        i_node.send(9'h0a4, 8, 1'b1);
        tick(4);
        check("rx_flag", rx_flag, 1'b0);
        @(posedge clk_i);
        rx_en <= 1'b0;
        tick(2);
        check("overrun", overrun_error_flag, 1'b0);
        @(posedge clk_i);
        {rx_en, rx9_on} <= 2'h3;
        tick(2);
        i_node.send(9'h1a5, 9, 1'b1);
        rd_rx(8'ha5, 1'b0, 1'b1);
        i_node.send(9'h066, 9, 1'b0);
        rd_rx(8'h66, 1'b1, 1'b0);
        // Synchronous select leaves the async port idle, pins follow direction
        @(posedge clk_i);
        sync <= 1'b1;
        tick(2);
        check("tx_oe_n", tx_oe_n, 1'b1);
        check("rx_oe_n", rx_oe_n, 1'b0);
        check("tx_flag", tx_flag, 1'b0);
        @(posedge clk_i);
        port_en <= 1'b0;
        tick(2);
        check("framing_error", framing_error_flag, 1'b0);
        check("tx_empty", tx_empty, 1'b1);
        $display("test errors done");
        tally_and_finish();
    end
endmodule // ast_transceiver_tb
`default_nettype wire
